// ---- src/term_pkg.sv ----
// Shared constants and types for the termination state selector
package term_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] MR_ONE_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] MR_TWO_OFS = 12'h004;
	localparam logic [ADDR_W-1:0] MR_FIVE_OFS = 12'h008;
	localparam logic [ADDR_W-1:0] LINK_CTRL_OFS = 12'h00c;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h010;

	// Field positions
	localparam int NOM_LSB = 8;
	localparam int WR_LSB = 9;
	localparam int PARK_LSB = 6;
	localparam int PRE_BIT = 0;
	localparam int CHOP_BIT = 1;
	localparam int RLAT_LSB = 8;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_CODE_LSB = 4;
	localparam int ST_SR_BIT = 8;
	localparam int ST_RX_BIT = 9;
	localparam int ST_EN_BIT = 10;

	// Values after reset
	localparam logic [2:0] NOM_RST = 3'h0;
	localparam logic [1:0] WR_RST = 2'h0;
	localparam logic [2:0] PARK_RST = 3'h0;
	localparam logic PRE_RST = 1'b0;
	localparam logic CHOP_RST = 1'b0;
	localparam logic [5:0] RLAT_RST = 6'h0b;

	// Cycle counts
	localparam logic [3:0] X_ONE = 4'h2;
	localparam logic [3:0] X_TWO = 4'h3;
	localparam logic [3:0] HALF_EIGHT = 4'h4;
	localparam logic [3:0] HALF_FOUR = 4'h2;

	localparam int LANES = 22;
	localparam int CFG_W = 16;
	localparam int STAT_W = 7;
	localparam logic [CFG_W-1:0] CFG_RST = {RLAT_RST, CHOP_RST, PRE_RST, PARK_RST, WR_RST, NOM_RST};
	localparam logic [STAT_W-1:0] STAT_RST = 7'h00;

	typedef enum logic [2:0] {TS_HIZ, TS_DISABLED, TS_WRITE, TS_NOMINAL, TS_PARK} term_state_e;

endpackage

// ---- src/sync2.sv ----
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module sync2
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic d,
	output logic q
);
	logic meta;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ---- src/word_cross.sv ----
// Toggle handshake carrying a word between two clock domains
`timescale 1ns/1ps
module word_cross
#(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	input wire logic src_clk,
	input wire logic src_rstn,
	input wire logic [W-1:0] src_data,
	input wire logic dst_clk,
	input wire logic dst_rstn,
	output logic [W-1:0] dst_data
);
	logic [W-1:0] held;
	logic req;
	logic ack;
	logic ack_s;
	logic req_s;

	// Held word stays still until the far side has taken it
	always_ff @(posedge src_clk or negedge src_rstn)
	begin
		if (!src_rstn)
		begin
			held <= RST_VAL;
			req <= 1'b0;
		end
		else if (ack_s == req && src_data != held)
		begin
			held <= src_data;
			req <= ~req;
		end
	end

	sync2 u_req (.clk(dst_clk), .rstn(dst_rstn), .d(req), .q(req_s));
	sync2 u_ack (.clk(src_clk), .rstn(src_rstn), .d(ack), .q(ack_s));

	always_ff @(posedge dst_clk or negedge dst_rstn)
	begin
		if (!dst_rstn)
		begin
			dst_data <= RST_VAL;
			ack <= 1'b0;
		end
		else if (req_s != ack)
		begin
			dst_data <= held;
			ack <= req_s;
		end
	end
endmodule

// ---- src/termination_state_select.sv ----
// On-die termination state selector with APB mode registers
`timescale 1ns/1ps
module termination_state_select
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [term_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [term_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [term_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic link_clk,
	input wire logic termination_pin,
	input wire logic cmd_write,
	input wire logic cmd_read,
	input wire logic self_refresh_enter,
	input wire logic self_refresh_exit,
	output term_pkg::term_state_e term_state,
	output logic [2:0] term_code,
	output logic [term_pkg::LANES-1:0] term_lanes,
	output logic pin_receiver_en
);
	import term_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Register side
	logic [2:0] nom_field;
	logic [1:0] wr_field;
	logic [2:0] park_field;
	logic pre_two;
	logic chop_four;
	logic [5:0] read_latency;
	logic [STAT_W-1:0] stat_p;
	logic hit;
	logic [DATA_W-1:0] rd_val;
	logic [DATA_W-1:0] wmask;
	logic [DATA_W-1:0] merged;
	logic wr_access;
	logic term_enabled;

	assign pready = 1'b1;
	assign wr_access = psel && penable && pwrite && hit;
	assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign merged = (rd_val & ~wmask) | (pwdata & wmask);

	assign term_enabled = (nom_field != 3'h0) || (wr_field != 2'h0) || (park_field != 3'h0);

	always_comb
	begin
		hit = 1'b1;
		rd_val = '0;
		if (paddr == MR_ONE_OFS)
		begin
			rd_val[NOM_LSB +: 3] = nom_field;
		end
		else if (paddr == MR_TWO_OFS)
		begin
			rd_val[WR_LSB +: 2] = wr_field;
		end
		else if (paddr == MR_FIVE_OFS)
		begin
			rd_val[PARK_LSB +: 3] = park_field;
		end
		else if (paddr == LINK_CTRL_OFS)
		begin
			rd_val[PRE_BIT] = pre_two;
			rd_val[CHOP_BIT] = chop_four;
			rd_val[RLAT_LSB +: 6] = read_latency;
		end
		else if (paddr == STATUS_OFS)
		begin
			rd_val[ST_STATE_LSB +: 3] = stat_p[2:0];
			rd_val[ST_CODE_LSB +: 3] = stat_p[5:3];
			rd_val[ST_SR_BIT] = stat_p[6];
			rd_val[ST_RX_BIT] = (nom_field != 3'h0);
			rd_val[ST_EN_BIT] = term_enabled;
		end
		else
		begin
			hit = 1'b0;
		end
	end

	assign pslverr = psel && penable && !hit;

	// Read data captured in setup so it is a flop during access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable)
			prdata <= rd_val;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			nom_field <= NOM_RST;
			wr_field <= WR_RST;
			park_field <= PARK_RST;
			pre_two <= PRE_RST;
			chop_four <= CHOP_RST;
			read_latency <= RLAT_RST;
		end
		else if (wr_access)
		begin
			if (paddr == MR_ONE_OFS)
				nom_field <= merged[NOM_LSB +: 3];
			else if (paddr == MR_TWO_OFS)
				wr_field <= merged[WR_LSB +: 2];
			else if (paddr == MR_FIVE_OFS)
				park_field <= merged[PARK_LSB +: 3];
			else if (paddr == LINK_CTRL_OFS)
			begin
				pre_two <= merged[PRE_BIT];
				chop_four <= merged[CHOP_BIT];
				read_latency <= merged[RLAT_LSB +: 6];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Crossings
	logic link_rstn;
	logic [CFG_W-1:0] cfg_link;
	logic [STAT_W-1:0] stat_link;

	// Reset asserts at once but leaves on a link edge
	sync2 u_lrst (.clk(link_clk), .rstn(presetn), .d(1'b1), .q(link_rstn));

	word_cross #(.W(CFG_W), .RST_VAL(CFG_RST)) u_cfg (
		.src_clk(pclk),
		.src_rstn(presetn),
		.src_data({read_latency, chop_four, pre_two, park_field, wr_field, nom_field}),
		.dst_clk(link_clk),
		.dst_rstn(link_rstn),
		.dst_data(cfg_link)
	);

	word_cross #(.W(STAT_W), .RST_VAL(STAT_RST)) u_stat (
		.src_clk(link_clk),
		.src_rstn(link_rstn),
		.src_data(stat_link),
		.dst_clk(pclk),
		.dst_rstn(presetn),
		.dst_data(stat_p)
	);

	////////////////////////////////////////////////////////////////////////////
	// Link side inputs
	logic pin_s;
	logic wr_s;
	logic rd_s;
	logic sre_s;
	logic srx_s;

	sync2 u_pin (.clk(link_clk), .rstn(link_rstn), .d(termination_pin), .q(pin_s));
	sync2 u_wr (.clk(link_clk), .rstn(link_rstn), .d(cmd_write), .q(wr_s));
	sync2 u_rd (.clk(link_clk), .rstn(link_rstn), .d(cmd_read), .q(rd_s));
	sync2 u_sre (.clk(link_clk), .rstn(link_rstn), .d(self_refresh_enter), .q(sre_s));
	sync2 u_srx (.clk(link_clk), .rstn(link_rstn), .d(self_refresh_exit), .q(srx_s));

	logic [2:0] l_nom;
	logic [1:0] l_wr;
	logic [2:0] l_park;
	logic [5:0] l_rlat;
	logic [3:0] x_val;
	logic [3:0] off_len;
	logic [5:0] start_delay;

	assign l_nom = cfg_link[2:0];
	assign l_wr = cfg_link[4:3];
	assign l_park = cfg_link[7:5];
	assign l_rlat = cfg_link[15:10];
	assign x_val = cfg_link[8] ? X_TWO : X_ONE;
	assign off_len = (cfg_link[9] ? HALF_FOUR : HALF_EIGHT) + x_val;
	assign start_delay = (l_rlat > {2'b00, x_val}) ? l_rlat - {2'b00, x_val} : 6'h00;

	////////////////////////////////////////////////////////////////////////////
	// Self refresh, read and write windows
	logic self_ref;
	logic rd_pending;
	logic [5:0] rd_delay;
	logic rd_start;
	logic [3:0] off_cnt;
	logic [3:0] wr_cnt;

	always_ff @(posedge link_clk or negedge link_rstn)
	begin
		if (!link_rstn)
			self_ref <= 1'b0;
		else if (sre_s)
			self_ref <= 1'b1;
		else if (srx_s)
			self_ref <= 1'b0;
	end

	assign rd_start = (rd_s && !self_ref && start_delay <= 6'h01)
		|| (rd_pending && rd_delay == 6'h01);

	// Only the newest read is tracked; a later one restarts the delay
	always_ff @(posedge link_clk or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			rd_pending <= 1'b0;
			rd_delay <= 6'h00;
		end
		else if (rd_s && !self_ref && start_delay > 6'h01)
		begin
			rd_pending <= 1'b1;
			rd_delay <= start_delay - 6'h01;
		end
		else if (rd_pending)
		begin
			rd_pending <= (rd_delay != 6'h01);
			rd_delay <= rd_delay - 6'h01;
		end
	end

	// off for half burst plus X
	always_ff @(posedge link_clk or negedge link_rstn)
	begin
		if (!link_rstn)
			off_cnt <= 4'h0;
		else if (self_ref)
			off_cnt <= 4'h0;
		else if (rd_start)
			off_cnt <= off_len;
		else if (off_cnt != 4'h0)
			off_cnt <= off_cnt - 4'h1;
	end

	always_ff @(posedge link_clk or negedge link_rstn)
	begin
		if (!link_rstn)
			wr_cnt <= 4'h0;
		else if (self_ref)
			wr_cnt <= 4'h0;
		else if (wr_s && l_wr != 2'h0)
			wr_cnt <= off_len;
		else if (wr_cnt != 4'h0)
			wr_cnt <= wr_cnt - 4'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Selection
	term_state_e next_state;
	logic [2:0] next_code;
	logic pin_eff;

	assign pin_eff = pin_s && (l_nom != 3'h0) && !self_ref;

	always_comb
	begin
		next_state = TS_HIZ;
		next_code = 3'h0;
		if (self_ref)
			next_state = TS_HIZ;
		else if (off_cnt != 4'h0)
			next_state = TS_DISABLED;
		else if (wr_cnt != 4'h0 && l_wr != 2'h0)
		begin
			next_state = TS_WRITE;
			next_code = {1'b0, l_wr};
		end
		else if (pin_eff)
		begin
			next_state = TS_NOMINAL;
			next_code = l_nom;
		end
		else if (!pin_s && l_park != 3'h0)
		begin
			next_state = TS_PARK;
			next_code = l_park;
		end
		else if (l_nom == 3'h0 && l_park != 3'h0)
		begin
			next_state = TS_PARK;
			next_code = l_park;
		end
	end

	always_ff @(posedge link_clk or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			term_state <= TS_HIZ;
			term_code <= 3'h0;
		end
		else
		begin
			term_state <= next_state;
			term_code <= next_code;
		end
	end

	always_ff @(posedge link_clk or negedge link_rstn)
	begin
		if (!link_rstn)
			term_lanes <= '0;
		else
			term_lanes <= {LANES{next_state == TS_WRITE || next_state == TS_NOMINAL
				|| next_state == TS_PARK}};
	end

	always_ff @(posedge link_clk or negedge link_rstn)
	begin
		if (!link_rstn)
			pin_receiver_en <= 1'b0;
		else
			pin_receiver_en <= (l_nom != 3'h0);
	end

	assign stat_link = {self_ref, term_code, term_state};

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_sr_hiz: assert property (@(posedge link_clk) disable iff (!link_rstn)
		self_ref |=> term_state == TS_HIZ && term_lanes == '0)
		else $error("self refresh did not give high impedance");

	a_read_wins: assert property (@(posedge link_clk) disable iff (!link_rstn)
		(off_cnt != 4'h0 && !self_ref) |=> term_state == TS_DISABLED)
		else $error("read disable lost priority");

	a_read_window: assert property (@(posedge link_clk) disable iff (!link_rstn)
		(rd_start && !self_ref) |=> off_cnt == $past(off_len))
		else $error("read off window length wrong");

	a_read_delay: assert property (@(posedge link_clk) disable iff (!link_rstn)
		(rd_s && !self_ref && start_delay == 6'h04 && !sre_s) |-> ##3 rd_start)
		else $error("read disable began at wrong cycle");

	a_write_term: assert property (@(posedge link_clk) disable iff (!link_rstn)
		(wr_cnt != 4'h0 && l_wr != 2'h0 && off_cnt == 4'h0 && !self_ref)
		|=> term_state == TS_WRITE && term_code[1:0] == $past(l_wr))
		else $error("write termination not applied");

	a_nom_pin: assert property (@(posedge link_clk) disable iff (!link_rstn)
		(pin_eff && wr_cnt == 4'h0 && off_cnt == 4'h0) |=> term_state == TS_NOMINAL)
		else $error("nominal termination missing");

	a_park_low: assert property (@(posedge link_clk) disable iff (!link_rstn)
		(!pin_s && l_park != 3'h0 && wr_cnt == 4'h0 && off_cnt == 4'h0 && !self_ref)
		|=> term_state == TS_PARK && term_code == $past(l_park))
		else $error("park termination missing");

	a_idle_hiz: assert property (@(posedge link_clk) disable iff (!link_rstn)
		(l_park == 3'h0 && !pin_eff && wr_cnt == 4'h0 && off_cnt == 4'h0)
		|=> term_state == TS_HIZ && term_code == 3'h0)
		else $error("idle state not high impedance");

	a_rx_off: assert property (@(posedge link_clk) disable iff (!link_rstn)
		(l_nom == 3'h0) [*2] |-> !pin_receiver_en)
		else $error("receiver powered with nominal disabled");

	a_mr_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_access && paddr == MR_ONE_OFS && pstrb[1]) |=> nom_field == $past(pwdata[10:8]))
		else $error("nominal field not stored");

	a_enable_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && paddr == STATUS_OFS)
		|=> prdata[ST_EN_BIT] == $past(term_enabled))
		else $error("enable flag mismatch");
endmodule

// ---- testbench/ctrl_model.sv ----
// Memory controller model driving the command side of the selector
`timescale 1ns/1ps
module ctrl_model
(
	input wire logic link_clk,
	output logic termination_pin,
	output logic cmd_write,
	output logic cmd_read,
	output logic self_refresh_enter,
	output logic self_refresh_exit
);
	initial
	begin
		termination_pin = 1'b0;
		cmd_write = 1'b0;
		cmd_read = 1'b0;
		self_refresh_enter = 1'b0;
		self_refresh_exit = 1'b0;
	end
	////////////////////////////////////////
	task automatic set_pin(input logic v);
		@(posedge link_clk);
		termination_pin <= v;
	endtask
	// Strobes last one link cycle; bits are write, read, enter, exit
	task automatic strobe(input logic [3:0] k);
		@(posedge link_clk);
		{cmd_write, cmd_read, self_refresh_enter, self_refresh_exit} <= k;
		@(posedge link_clk);
		{cmd_write, cmd_read, self_refresh_enter, self_refresh_exit} <= 4'h0;
	endtask
endmodule

// ---- testbench/termination_state_select_tb_top.sv ----
// Self-checking bench for the termination state selector
`timescale 1ns/1ps
module termination_state_select_tb_top;
	import term_pkg::*;
	logic pclk = 1'b0;
	logic link_clk = 1'b0;
	logic presetn = 1'b0;
	logic [ADDR_W-1:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [DATA_W-1:0] pwdata;
	logic [3:0] pstrb;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic termination_pin;
	logic cmd_write;
	logic cmd_read;
	logic sr_enter;
	logic sr_exit;
	term_state_e term_state;
	term_state_e ps;
	logic [2:0] term_code;
	logic [LANES-1:0] term_lanes;
	logic pin_receiver_en;
	logic [DATA_W-1:0] rd;
	logic err;
	int fails = 0;
	int tests_run = 0;
	int rl[4] = '{11, 4, 2, 7};
	int n;
	int x;
	int len;
	int d;
	int lw;

	always #4 pclk = ~pclk;
	// Odd offset keeps the link clock out of step with pclk
	initial #1.3 forever #6 link_clk = ~link_clk;

	termination_state_select termination_state_select_inst
	(
		.pclk(pclk),
		.presetn(presetn),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.link_clk(link_clk),
		.termination_pin(termination_pin),
		.cmd_write(cmd_write),
		.cmd_read(cmd_read),
		.self_refresh_enter(sr_enter),
		.self_refresh_exit(sr_exit),
		.term_state(term_state),
		.term_code(term_code),
		.term_lanes(term_lanes),
		.pin_receiver_en(pin_receiver_en)
	);

	ctrl_model ctrl_model_inst
	(
		.link_clk(link_clk),
		.termination_pin(termination_pin),
		.cmd_write(cmd_write),
		.cmd_read(cmd_read),
		.self_refresh_enter(sr_enter),
		.self_refresh_exit(sr_exit)
	);
	////////////////////////////////////////
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic bail;
		fails++;
		tally_and_finish;
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
			bail;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_is(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		apb(1'b0, a, '0);
		check(rd, exp);
	endtask

	// Status lags the link by a crossing, so poll it
	task automatic status_is(input logic [DATA_W-1:0] exp);
		int k;
		k = 0;
		do
		begin
			apb(1'b0, STATUS_OFS, '0);
			k++;
		end
		while (rd !== exp && k < 40);
		check(rd, exp);
	endtask

	task automatic wait_out(input term_state_e s, input logic [2:0] c);
		int k;
		k = 0;
		while ((term_state !== s || term_code !== c) && k < 99)
		begin
			@(posedge link_clk);
			#1;
			k++;
		end
		if (term_state !== s || term_code !== c)
			bail;
		check(term_lanes, {LANES{s inside {TS_WRITE, TS_NOMINAL, TS_PARK}}});
	endtask
	////////////////////////////////////////
	initial
	begin
		paddr <= '0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		pwdata <= '0;
		pstrb <= 4'hf;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check({term_state, term_code, pin_receiver_en}, '0);
		check(term_lanes, '0);
		rd_is(LINK_CTRL_OFS, 32'h0b00);
		rd_is(STATUS_OFS, '0);
		apb(1'b0, 12'h014, '0);
		check(rd, '0);
		check(err, 1'b1);
		apb(1'b1, MR_ONE_OFS, '1);
		apb(1'b1, MR_TWO_OFS, '1);
		apb(1'b1, MR_FIVE_OFS, '1);
		rd_is(MR_ONE_OFS, 32'h700);
		rd_is(MR_TWO_OFS, 32'h600);
		rd_is(MR_FIVE_OFS, 32'h1c0);
		// Lane 1 masked, so the field keeps its value
		pstrb <= 4'h1;
		apb(1'b1, MR_ONE_OFS, '0);
		pstrb <= 4'hf;
		rd_is(MR_ONE_OFS, 32'h700);
		$display("end of register test");
		apb(1'b1, MR_ONE_OFS, '0);
		apb(1'b1, MR_TWO_OFS, '0);
		apb(1'b1, MR_FIVE_OFS, 32'h140);
		ctrl_model_inst.set_pin(1'b1);
		wait_out(TS_PARK, 3'h5);
		status_is(32'h454);
		check(pin_receiver_en, 1'b0);
		$display("end of park test");
		apb(1'b1, MR_ONE_OFS, 32'h300);
		wait_out(TS_NOMINAL, 3'h3);
		status_is(32'h633);
		ctrl_model_inst.set_pin(1'b0);
		wait_out(TS_PARK, 3'h5);
		apb(1'b1, MR_FIVE_OFS, '0);
		wait_out(TS_HIZ, 3'h0);
		$display("end of nominal test");
		apb(1'b1, MR_TWO_OFS, 32'h400);
		ctrl_model_inst.set_pin(1'b1);
		wait_out(TS_NOMINAL, 3'h3);
		repeat (20) @(posedge pclk);
		ctrl_model_inst.strobe(4'h8);
		wait_out(TS_WRITE, 3'h2);
		wait_out(TS_NOMINAL, 3'h3);
		// Write and read together: the read window always wins
		foreach (rl[m])
		begin
			apb(1'b1, LINK_CTRL_OFS, DATA_W'(rl[m] * 256 + m));
			repeat (30) @(posedge pclk);
			x = m[0] ? 3 : 2;
			d = rl[m] - x > 1 ? rl[m] - x : 1;
			lw = (m[1] ? 2 : 4) + x;
			ctrl_model_inst.strobe(4'hc);
			#1;
			n = 1;
			ps = term_state;
			while (term_state !== TS_DISABLED && n < 40)
			begin
				ps = term_state;
				@(posedge link_clk);
				#1;
				n++;
			end
			// Write window shows only if it still runs just before the read one
			check(ps, (d > 1 && d <= lw + 1) ? TS_WRITE : TS_NOMINAL);
			check(n, d + 3);
			len = 0;
			while (term_state === TS_DISABLED && len < 40)
			begin
				@(posedge link_clk);
				#1;
				len++;
			end
			check(len, lw);
			wait_out(TS_NOMINAL, 3'h3);
		end
		$display("end of read test");
		ctrl_model_inst.strobe(4'h2);
		wait_out(TS_HIZ, 3'h0);
		status_is(32'h700);
		ctrl_model_inst.strobe(4'h4);
		#1;
		err = 1'b0;
		repeat (20)
		begin
			@(posedge link_clk);
			#1;
			err = err | (term_state !== TS_HIZ);
		end
		check(err, 1'b0);
		ctrl_model_inst.strobe(4'h1);
		wait_out(TS_NOMINAL, 3'h3);
		$display("end of self refresh test");
		tally_and_finish;
	end
endmodule
